// *** inc/oselg_defines.svh ***
`ifndef OSELG_DEFINES_SVH
`define OSELG_DEFINES_SVH

// Register addresses (6-bit immediate set)
`define OSELG_ADDR_RISE_WR 6'h0d
`define OSELG_ADDR_RISE_SET 6'h0e
`define OSELG_ADDR_RISE_CLR 6'h0f
`define OSELG_ADDR_FALL_WR 6'h10
`define OSELG_ADDR_FALL_SET 6'h11
`define OSELG_ADDR_FALL_CLR 6'h12
`define OSELG_ADDR_LIVE 6'h13
`define OSELG_ADDR_LATCH 6'h14

// Field layout
`define OSELG_NSRC 5
`define OSELG_BIT_ID 4
`define OSELG_BIT_SEND 3
`define OSELG_BIT_SVLD 2
`define OSELG_BIT_VBUS 1
`define OSELG_BIT_HDISC 0

// Reset values
`define OSELG_RISE_RST 8'h1f
`define OSELG_FALL_RST 8'h1f
`define OSELG_LATCH_RST 8'h00
`define OSELG_ZERO8 8'h00
`define OSELG_ZERO5 5'h00

`endif

// *** inc/oselg_pkg.sv ***
package oselg_pkg;
   typedef enum logic [1:0] {
      OSELG_WR_PLAIN,
      OSELG_WR_SET,
      OSELG_WR_CLR
   } oselg_wr_kind_t;
   typedef logic [7:0] oselg_byte_t;
endpackage

// *** core/oselg_edge.sv ***
`timescale 1ns/100ps
`include "oselg_defines.svh"

module oselg_edge #(
   parameter int NSRC = `OSELG_NSRC
) (
   input wire logic sys_clk, // Clock
   input wire logic sys_rst, // Sync reset, active high
   input wire logic clk_en, // Clock enable
   input wire logic [NSRC-1:0] src_in, // Source levels
   input wire logic [NSRC-1:0] rise_en, // Rising enables
   input wire logic [NSRC-1:0] fall_en, // Falling enables
   output logic [NSRC-1:0] live_q, // Registered live level
   output logic [NSRC-1:0] event_d // Enabled edge this cycle, masked by rise_en/fall_en
);
   logic [NSRC-1:0] prev_q;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         live_q <= '0;
         prev_q <= '0;
      end else if (clk_en) begin
         live_q <= src_in;
         prev_q <= live_q;
      end
   end

   // Compare with previous sample; one event per source per cycle
   genvar i;
   generate
      for (i = 0; i < NSRC; i++) begin : g_src
         assign event_d[i] = clk_en & ((live_q[i] & ~prev_q[i] & rise_en[i]) |
                                       (~live_q[i] & prev_q[i] & fall_en[i]));
      end
   endgenerate
endmodule

// *** core/oselg_top.sv ***
`timescale 1ns/100ps
`include "oselg_defines.svh"

module oselg_top
   import oselg_pkg::*;
(
   input wire logic sys_clk, // Clock 200 MHz
   input wire logic sys_rst, // Sync reset, active high
   input wire logic clk_en, // Freezes all state when low
   input wire logic id_pin_grounded, // Id detector
   input wire logic session_ended, // Session end comparator
   input wire logic session_ok, // Session valid comparator
   input wire logic bus_power_ok, // Bus power valid comparator
   input wire logic host_link_lost, // Host disconnect detector
   input wire logic low_power_mode, // Level: device in low-power mode
   input wire logic serial_mode, // Level: device in serial mode
   input wire logic reg_wr, // Register write strobe
   input wire logic reg_rd, // Register read strobe
   input wire logic [5:0] reg_addr, // Register address
   input wire logic [7:0] reg_wdata, // Write data
   output logic [7:0] reg_rdata_q, // Read data, valid cycle after reg_rd
   output logic intr_q, // One-cycle interrupt pulse
   output logic rxcmd_req_q, // One-cycle RXCMD request pulse
   output logic [4:0] rxcmd_state_q // Source levels carried with RXCMD
);
   localparam int NSRC = `OSELG_NSRC;

   logic [7:0] rise_q;
   logic [7:0] fall_q;
   logic [NSRC-1:0] latch_q;
   logic [NSRC-1:0] live_q;
   logic [NSRC-1:0] event_d;
   logic [NSRC-1:0] src_in;
   logic mode_prev_q;
   logic mode_entry;

   // ----------------------------------------
   // Source mapping
   // ----------------------------------------
   assign src_in[`OSELG_BIT_ID] = id_pin_grounded;
   assign src_in[`OSELG_BIT_SEND] = session_ended;
   assign src_in[`OSELG_BIT_SVLD] = session_ok;
   assign src_in[`OSELG_BIT_VBUS] = bus_power_ok;
   assign src_in[`OSELG_BIT_HDISC] = host_link_lost;

   oselg_edge #(
      .NSRC(NSRC)
   ) u_edge (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .src_in(src_in),
      .rise_en(rise_q[NSRC-1:0]),
      .fall_en(fall_q[NSRC-1:0]),
      .live_q(live_q),
      .event_d(event_d)
   );

   // ----------------------------------------
   // Register write decode
   // ----------------------------------------
   function automatic logic [7:0] apply_wr(input logic [7:0] cur, input logic [7:0] wd,
                                           input oselg_wr_kind_t kind);
      logic [7:0] r;
      r = cur;
      case (kind)
         OSELG_WR_PLAIN: r = wd;
         OSELG_WR_SET: r = cur | wd;
         OSELG_WR_CLR: r = cur & ~wd;
         default: r = cur;
      endcase
      return r;
   endfunction

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rise_q <= `OSELG_RISE_RST;
      end else if (clk_en && reg_wr) begin
         case (reg_addr)
            `OSELG_ADDR_RISE_WR: rise_q <= apply_wr(rise_q, reg_wdata, OSELG_WR_PLAIN);
            `OSELG_ADDR_RISE_SET: rise_q <= apply_wr(rise_q, reg_wdata, OSELG_WR_SET);
            `OSELG_ADDR_RISE_CLR: rise_q <= apply_wr(rise_q, reg_wdata, OSELG_WR_CLR);
            default: rise_q <= rise_q;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         fall_q <= `OSELG_FALL_RST;
      end else if (clk_en && reg_wr) begin
         case (reg_addr)
            `OSELG_ADDR_FALL_WR: fall_q <= apply_wr(fall_q, reg_wdata, OSELG_WR_PLAIN);
            `OSELG_ADDR_FALL_SET: fall_q <= apply_wr(fall_q, reg_wdata, OSELG_WR_SET);
            `OSELG_ADDR_FALL_CLR: fall_q <= apply_wr(fall_q, reg_wdata, OSELG_WR_CLR);
            default: fall_q <= fall_q;
         endcase
      end
   end

   // ----------------------------------------
   // Latch, events and mode entry
   // ----------------------------------------
   assign mode_entry = (low_power_mode | serial_mode) & ~mode_prev_q;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         mode_prev_q <= 1'b0;
      end else if (clk_en) begin
         mode_prev_q <= low_power_mode | serial_mode;
      end
   end

   // New events win over a read clear so none is lost
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         latch_q <= `OSELG_ZERO5;
      end else if (clk_en) begin
         if (mode_entry) begin
            latch_q <= `OSELG_ZERO5;
         end else if (reg_rd && reg_addr == `OSELG_ADDR_LATCH) begin
            latch_q <= event_d;
         end else begin
            latch_q <= latch_q | event_d;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         intr_q <= 1'b0;
         rxcmd_req_q <= 1'b0;
         rxcmd_state_q <= `OSELG_ZERO5;
      end else if (clk_en) begin
         intr_q <= |event_d;
         rxcmd_req_q <= |event_d;
         rxcmd_state_q <= live_q;
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         reg_rdata_q <= `OSELG_ZERO8;
      end else if (clk_en && reg_rd) begin
         case (reg_addr)
            `OSELG_ADDR_RISE_WR, `OSELG_ADDR_RISE_SET, `OSELG_ADDR_RISE_CLR:
               reg_rdata_q <= rise_q;
            `OSELG_ADDR_FALL_WR, `OSELG_ADDR_FALL_SET, `OSELG_ADDR_FALL_CLR:
               reg_rdata_q <= fall_q;
            `OSELG_ADDR_LIVE: reg_rdata_q <= {3'h0, live_q};
            `OSELG_ADDR_LATCH: reg_rdata_q <= {3'h0, latch_q};
            default: reg_rdata_q <= `OSELG_ZERO8;
         endcase
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence s_rise_id;
      clk_en && live_q[`OSELG_BIT_ID] && !$past(live_q[`OSELG_BIT_ID]) && rise_q[`OSELG_BIT_ID];
   endsequence

   property p_rise_intr;
      @(posedge sys_clk) disable iff (sys_rst) s_rise_id |=> intr_q && rxcmd_req_q;
   endproperty
   a_rise_intr: assert property (p_rise_intr) else $error("rise event lost");

   property p_fall_intr;
      @(posedge sys_clk) disable iff (sys_rst)
         clk_en && !live_q[`OSELG_BIT_SEND] && $past(live_q[`OSELG_BIT_SEND])
         && fall_q[`OSELG_BIT_SEND] |=> intr_q;
   endproperty
   a_fall_intr: assert property (p_fall_intr) else $error("fall event lost");

   // A frozen cycle leaves an earlier edge pending, so require an enabled cycle before
   property p_no_spurious;
      @(posedge sys_clk) disable iff (sys_rst)
         clk_en && $past(clk_en) && live_q == $past(live_q) |=> !intr_q;
   endproperty
   a_no_spurious: assert property (p_no_spurious) else $error("interrupt without change");

   property p_latch_set;
      @(posedge sys_clk) disable iff (sys_rst)
         clk_en && !mode_entry && event_d[`OSELG_BIT_VBUS] |=> latch_q[`OSELG_BIT_VBUS];
   endproperty
   a_latch_set: assert property (p_latch_set) else $error("latch not set");

   property p_read_clear;
      @(posedge sys_clk) disable iff (sys_rst)
         clk_en && reg_rd && reg_addr == `OSELG_ADDR_LATCH && event_d == '0 |=> latch_q == '0;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("latch not cleared by read");

   property p_mode_clear;
      @(posedge sys_clk) disable iff (sys_rst) clk_en && mode_entry |=> latch_q == '0;
   endproperty
   a_mode_clear: assert property (p_mode_clear) else $error("latch not cleared on mode");

   property p_live_read;
      @(posedge sys_clk) disable iff (sys_rst)
         clk_en && reg_rd && reg_addr == `OSELG_ADDR_LIVE |=> reg_rdata_q == {3'h0, $past(live_q)};
   endproperty
   a_live_read: assert property (p_live_read) else $error("live state read wrong");

   property p_rise_set;
      @(posedge sys_clk) disable iff (sys_rst)
         clk_en && reg_wr && reg_addr == `OSELG_ADDR_RISE_SET
         |=> rise_q == ($past(rise_q) | $past(reg_wdata));
   endproperty
   a_rise_set: assert property (p_rise_set) else $error("rise set wrong");

   property p_fall_clr;
      @(posedge sys_clk) disable iff (sys_rst)
         clk_en && reg_wr && reg_addr == `OSELG_ADDR_FALL_CLR
         |=> fall_q == ($past(fall_q) & ~$past(reg_wdata));
   endproperty
   a_fall_clr: assert property (p_fall_clr) else $error("fall clear wrong");

   property p_reset_vals;
      @(posedge sys_clk) $fell(sys_rst) |-> rise_q == `OSELG_RISE_RST && fall_q == `OSELG_FALL_RST;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("enable reset value wrong");
endmodule

// *** bench/oselg_link_model.sv ***
`timescale 1ns/100ps

// ----------------------------------------
// Link controller side
// ----------------------------------------
module oselg_link_model (
   input wire logic sys_clk, // Clock
   input wire logic sys_rst, // Sync reset
   input wire logic rxcmd_req_q, // RXCMD request pulse
   input wire logic [4:0] rxcmd_state_q, // Levels carried with RXCMD
   input wire logic drain_start, // Start bus power drain
   output logic bus_power_drain_q, // Drain control
   output int rxcmd_cnt_q // RXCMDs taken
);
   logic send_seen_q;

   // Uses RXCMDs only, never needs the latch
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rxcmd_cnt_q <= 0;
         send_seen_q <= 1'b0;
      end else if (rxcmd_req_q) begin
         rxcmd_cnt_q <= rxcmd_cnt_q + 1;
         send_seen_q <= rxcmd_state_q[3];
      end
   end

   // Stop drain once an RXCMD shows session end rising
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         bus_power_drain_q <= 1'b0;
      end else if (drain_start) begin
         bus_power_drain_q <= 1'b1;
      end else if (rxcmd_req_q && rxcmd_state_q[3] && !send_seen_q) begin
         bus_power_drain_q <= 1'b0;
      end
   end
endmodule

// *** bench/tb.sv ***
`timescale 1ns/100ps
`include "oselg_defines.svh"

module tb;
   import oselg_pkg::*;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_en = 1'b1;
   logic [4:0] src = 5'h00;
   logic low_power_mode = 1'b0;
   logic serial_mode = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [5:0] reg_addr = 6'h00;
   oselg_byte_t reg_wdata = 8'h00;
   oselg_byte_t reg_rdata_q;
   logic intr_q;
   logic rxcmd_req_q;
   logic [4:0] rxcmd_state_q;
   logic drain_start = 1'b0;
   logic bus_power_drain_q;
   int rxcmd_cnt_q;
   int intr_cnt = 0;
   int failures = 0;
   int tests_run = 0;

   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (intr_q === 1'b1) intr_cnt++;
   end

   oselg_top oselg_top_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .id_pin_grounded(src[4]), .session_ended(src[3]), .session_ok(src[2]),
      .bus_power_ok(src[1]), .host_link_lost(src[0]), .low_power_mode(low_power_mode),
      .serial_mode(serial_mode), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .intr_q(intr_q),
      .rxcmd_req_q(rxcmd_req_q), .rxcmd_state_q(rxcmd_state_q));

   oselg_link_model oselg_link_model_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .rxcmd_req_q(rxcmd_req_q), .rxcmd_state_q(rxcmd_state_q), .drain_start(drain_start),
      .bus_power_drain_q(bus_power_drain_q), .rxcmd_cnt_q(rxcmd_cnt_q));

   // ----------------------------------------
   // Access and check tasks
   // ----------------------------------------
   task automatic stop_test;
      $display("Checks %0d, failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      chk(reg_rdata_q, exp);
   endtask

   // Apply source levels, count interrupts and RXCMDs that follow
   task automatic ev(input logic [4:0] s, input int n);
      int i0;
      int r0;
      i0 = intr_cnt;
      r0 = rxcmd_cnt_q;
      @(posedge sys_clk);
      src <= s;
      repeat (5) @(posedge sys_clk);
      chk(8'(intr_cnt - i0), 8'(n));
      chk(8'(rxcmd_cnt_q - r0), 8'(n));
      chk({3'h0, rxcmd_state_q}, {3'h0, s});
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge sys_clk);
      sys_rst <= 1'b0;
      for (int a = 'h0d; a <= 'h12; a++) rdc(6'(a), 8'h1f);
      rdc(`OSELG_ADDR_LIVE, 8'h00);
      rdc(`OSELG_ADDR_LATCH, `OSELG_LATCH_RST);
      rdc(6'h15, 8'h00);
      for (int i = 0; i < 5; i++) begin
         ev(5'h01 << i, 1);
         rdc(`OSELG_ADDR_LIVE, 8'h01 << i);
         rdc(`OSELG_ADDR_LATCH, 8'h01 << i);
         rdc(`OSELG_ADDR_LATCH, 8'h00);
         ev(5'h00, 1);
         rdc(`OSELG_ADDR_LATCH, 8'h01 << i);
      end
      wr(`OSELG_ADDR_RISE_WR, 8'ha5);
      rdc(`OSELG_ADDR_RISE_SET, 8'ha5);
      wr(`OSELG_ADDR_RISE_SET, 8'h02);
      rdc(`OSELG_ADDR_RISE_CLR, 8'ha7);
      wr(`OSELG_ADDR_RISE_CLR, 8'h05);
      rdc(`OSELG_ADDR_RISE_WR, 8'ha2);
      wr(`OSELG_ADDR_FALL_WR, 8'h08);
      wr(`OSELG_ADDR_FALL_SET, 8'h11);
      wr(`OSELG_ADDR_FALL_CLR, 8'h01);
      rdc(`OSELG_ADDR_FALL_SET, 8'h18);
      ev(5'h01, 0);
      ev(5'h03, 1);
      rdc(`OSELG_ADDR_LATCH, 8'h02);
      ev(5'h02, 0);
      ev(5'h1a, 0);
      ev(5'h02, 1);
      rdc(`OSELG_ADDR_LATCH, 8'h18);
      wr(`OSELG_ADDR_RISE_WR, 8'h1f);
      ev(5'h0a, 1);
      low_power_mode <= 1'b1;
      rdc(`OSELG_ADDR_LATCH, 8'h00);
      low_power_mode <= 1'b0;
      ev(5'h02, 1);
      serial_mode <= 1'b1;
      rdc(`OSELG_ADDR_LATCH, 8'h00);
      serial_mode <= 1'b0;
      @(posedge sys_clk);
      clk_en <= 1'b0;
      reg_wr <= 1'b1;
      reg_addr <= `OSELG_ADDR_RISE_WR;
      reg_wdata <= 8'h00;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      clk_en <= 1'b1;
      rdc(`OSELG_ADDR_RISE_WR, 8'h1f);
      @(posedge sys_clk);
      drain_start <= 1'b1;
      @(posedge sys_clk);
      drain_start <= 1'b0;
      @(posedge sys_clk);
      chk({7'h00, bus_power_drain_q}, 8'h01);
      ev(5'h0a, 1);
      chk({7'h00, bus_power_drain_q}, 8'h00);
      // Edge taken just before a frozen stretch is delayed, not lost
      @(posedge sys_clk);
      src <= 5'h02;
      @(posedge sys_clk);
      clk_en <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk({7'h00, intr_q}, 8'h00);
      clk_en <= 1'b1;
      ev(5'h02, 1);
      stop_test;
   end

   initial begin
      #20000;
      failures++;
      stop_test;
   end
endmodule
